// file: hdl/acss_step_timer.sv
// Switching-cycle divider that paces the 40 ns soft start steps
`timescale 1ns/100ps
module acss_step_timer
  import acss_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic       cycle_start,
  input  wire logic [1:0] rate_code,
  output logic            step
);
  logic [3:0] count_reg;
  logic [3:0] last;

  assign last = acss_cycles_per_step(rate_code) - 4'h1;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      count_reg <= 4'h0;
      step      <= 1'b0;
    end
    else if (cycle_start)
    begin
      // Rate changes take effect at once; a count past the new end wraps now
      if (count_reg >= last)
      begin
        count_reg <= 4'h0;
        step      <= 1'b1; // [RULE_03]
      end
      else
      begin
        count_reg <= count_reg + 4'h1;
        step      <= 1'b0;
      end
    end
    else
    begin
      step <= 1'b0;
    end
  end
endmodule : acss_step_timer

// file: hdl/acss_top.sv
// Aux channel soft start edge ramping with AXI4-Lite configuration
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
// Overview of operation
// [RULE_01] Order bit 7 set: pins 1,2,5,6 fall after they rise each cycle.
// [RULE_02] Bit 6 used only with bit 7: 0 pins 3,4,7,8 rise after fall.
// [RULE_03] Rate code 0..3 applies one 40 ns step per 1, 2, 4 or 8 cycles.
// [RULE_04] Global bit clear: odd and even variation separate; set: all use pin 2.
// [RULE_05] A config bit selects the pin 2 variation formula.
// [RULE_06] Formula 0 is fall minus rise; formula 1 is period minus rise.
// [RULE_07] Odd source bit picks pin 1 or pin 3 edges; ignored under global.
// [RULE_08] Even source bit picks pin 2 or pin 4 edges; ignored under global.
// [RULE_09] Count cycles, step 40 ns per elapsed count, stop at final edges.
module acss_top
  import acss_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [15:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [15:0] period_ticks,
  input  wire logic [15:0] rise_ticks [8],
  input  wire logic [15:0] fall_ticks [8],
  output logic             pwm_pin_1,
  output logic             pwm_pin_2,
  output logic             pwm_pin_3,
  output logic             pwm_pin_4,
  output logic             pwm_pin_5,
  output logic             pwm_pin_6,
  output logic             pwm_pin_7,
  output logic             pwm_pin_8,
  output logic             soft_start_active,
  output logic             soft_start_done
);
  logic [7:0]  cfg_reg;
  logic        enable_reg;
  logic        start_reg;
  acss_state_t state_reg;
  logic [15:0] tick_reg;
  logic        cycle_start;
  logic [15:0] odd_ramp_reg;
  logic [15:0] even_ramp_reg;
  logic [15:0] odd_target;
  logic [15:0] even_target;
  logic [15:0] p2_var;
  logic        step;
  logic [7:0]  pins_next;
  logic [7:0]  pins_reg;
  logic [15:0] aw_addr_reg;
  logic        aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_held_reg;
  logic        do_write;
  // Pulse width of an edge pair, allowing the pulse to wrap the cycle end
  function automatic logic [15:0] span(input logic [15:0] r, input logic [15:0] f,
                                       input logic [15:0] p);
    span = (f >= r) ? f - r : p - r + f;
  endfunction : span
  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction : min16
  // High between start and end; start above end means the pulse wraps
  function automatic logic level(input logic [15:0] t, input logic [15:0] s,
                                 input logic [15:0] e);
    level = (s <= e) ? (t >= s && t < e) : (t >= s || t < e);
  endfunction : level
  // AXI4-Lite slave; ready stays low while a response waits
  assign do_write = aw_held_reg && w_held_reg && !bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready     <= 1'b0;
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 16'h0000;
    end
    else if (awready && awvalid)
    begin
      awready     <= 1'b0;
      aw_held_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end
    else
    begin
      aw_held_reg <= aw_held_reg && !do_write;
      awready     <= !aw_held_reg && !awready && !bvalid;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready     <= 1'b0;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else if (wready && wvalid)
    begin
      wready     <= 1'b0;
      w_held_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end
    else
    begin
      w_held_reg <= w_held_reg && !do_write;
      wready     <= !w_held_reg && !wready && !bvalid;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp  <= (aw_addr_reg == ADDR_CFG || aw_addr_reg == ADDR_CTRL ||
                 aw_addr_reg == ADDR_STATUS || aw_addr_reg == ADDR_RAMP) ?
                RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
    begin
      bvalid <= 1'b0;
    end
  end
  // Configuration is sampled live; changing it mid-ramp alters the ramp at once
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_reg    <= CFG_RESET;
      enable_reg <= CTRL_RESET[CTRL_ENABLE];
      start_reg  <= CTRL_RESET[CTRL_START];
    end
    else
    begin
      start_reg <= 1'b0;
      if (do_write && w_strb_reg[0])
      begin
        if (aw_addr_reg == ADDR_CFG)
        begin
          cfg_reg <= w_data_reg[7:0];
        end
        if (aw_addr_reg == ADDR_CTRL)
        begin
          enable_reg <= w_data_reg[CTRL_ENABLE];
          start_reg  <= w_data_reg[CTRL_START];
        end
      end
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end
    else if (rvalid)
    begin
      rvalid <= !rready;
    end
    else if (arready && arvalid)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= RESP_OKAY;
      unique case (araddr)
        ADDR_CFG:    rdata <= {24'h000000, cfg_reg};
        ADDR_CTRL:   rdata <= {31'h00000000, enable_reg};
        ADDR_STATUS: rdata <= {30'h00000000, soft_start_done, soft_start_active};
        ADDR_RAMP:   rdata <= {even_ramp_reg, odd_ramp_reg};
        default:
        begin
          rdata <= 32'h0000_0000;
          rresp <= RESP_SLVERR;
        end
      endcase
    end
    else
    begin
      arready <= !arready;
    end
  end
  // Switching cycle timebase; a shorter period cuts the running cycle at once
  assign cycle_start = (tick_reg == 16'h0000);
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !enable_reg || tick_reg + 16'h0001 >= period_ticks)
    begin
      tick_reg <= 16'h0000;
    end
    else
    begin
      tick_reg <= tick_reg + 16'h0001;
    end
  end
  // Variation targets
  always_comb
  begin
    p2_var = cfg_reg[CFG_P2_FORM] ? period_ticks - rise_ticks[1] // [RULE_05] [RULE_06]
                                  : span(rise_ticks[1], fall_ticks[1], period_ticks);
    if (cfg_reg[CFG_GLOBAL])
    begin
      odd_target  = p2_var; // [RULE_04]
      even_target = p2_var;
    end
    else
    begin
      odd_target  = cfg_reg[CFG_ODD_SEL] ? // [RULE_07]
                    span(rise_ticks[2], fall_ticks[2], period_ticks) :
                    span(rise_ticks[0], fall_ticks[0], period_ticks);
      even_target = cfg_reg[CFG_EVEN_SEL] ? // [RULE_08]
                    span(rise_ticks[3], fall_ticks[3], period_ticks) : p2_var;
    end
  end
  // Soft start sequencing
  acss_step_timer u_step_timer (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .run         (state_reg == ACSS_RAMP),
    .cycle_start (cycle_start),
    .rate_code   (cfg_reg[CFG_RATE_HI:CFG_RATE_LO]),
    .step        (step)
  );
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !enable_reg)
    begin
      state_reg     <= ACSS_IDLE;
      odd_ramp_reg  <= 16'h0000;
      even_ramp_reg <= 16'h0000;
    end
    else if (start_reg)
    begin
      state_reg     <= ACSS_RAMP;
      odd_ramp_reg  <= 16'h0000;
      even_ramp_reg <= 16'h0000;
    end
    else if (state_reg == ACSS_RAMP)
    begin
      if (odd_ramp_reg >= odd_target && even_ramp_reg >= even_target)
      begin
        state_reg <= ACSS_DONE; // [RULE_09]
      end
      else if (step)
      begin
        // Clamp so the last step lands exactly on the final on-time
        odd_ramp_reg  <= min16(odd_ramp_reg + STEP_TICKS, odd_target); // [RULE_09]
        even_ramp_reg <= min16(even_ramp_reg + STEP_TICKS, even_target);
      end
    end
  end
  // Edge placement
  always_comb
  begin
    logic [15:0] on_t;
    logic [15:0] half;
    logic [15:0] s;
    logic [15:0] e;
    on_t      = 16'h0000;
    half      = 16'h0000;
    s         = 16'h0000;
    e         = 16'h0000;
    pins_next = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      s = rise_ticks[i];
      e = fall_ticks[i];
      if (state_reg == ACSS_RAMP)
      begin
        // Index bit 0 even means pins 1,3,5,7 (odd group)
        on_t = min16(i[0] ? even_ramp_reg : odd_ramp_reg,
                     span(rise_ticks[i], fall_ticks[i], period_ticks));
        half = on_t >> 1;
        if (!cfg_reg[CFG_A_ORDER])
        begin
          s = (fall_ticks[i] >= on_t) ? fall_ticks[i] - on_t
                                      : fall_ticks[i] + period_ticks - on_t;
          e = fall_ticks[i];
        end
        else if (!i[1] || cfg_reg[CFG_B_ORDER])
        begin
          s = rise_ticks[i]; // [RULE_01] [RULE_02]
          e = min16(rise_ticks[i] + on_t, period_ticks);
        end
        else
        begin
          s = period_ticks - (on_t - half); // [RULE_02]
          e = half;
        end
      end
      pins_next[i] = (state_reg != ACSS_IDLE) && level(tick_reg, s, e);
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pins_reg          <= 8'h00;
      soft_start_active <= 1'b0;
      soft_start_done   <= 1'b0;
    end
    else
    begin
      pins_reg          <= pins_next;
      soft_start_active <= (state_reg == ACSS_RAMP);
      soft_start_done   <= (state_reg == ACSS_DONE);
    end
  end
  assign pwm_pin_1 = pins_reg[0];
  assign pwm_pin_2 = pins_reg[1];
  assign pwm_pin_3 = pins_reg[2];
  assign pwm_pin_4 = pins_reg[3];
  assign pwm_pin_5 = pins_reg[4];
  assign pwm_pin_6 = pins_reg[5];
  assign pwm_pin_7 = pins_reg[6];
  assign pwm_pin_8 = pins_reg[7];
endmodule : acss_top

// file: shared/acss_pkg.sv
// Constants, register map and helpers for the aux channel soft start block
package acss_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned STEP_NS       = 40;
  localparam int unsigned STEP_CYCLES   = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] STEP_TICKS    = 16'(STEP_CYCLES);

  localparam logic [15:0] ADDR_CFG    = 16'hFE68;
  localparam logic [15:0] ADDR_CTRL   = 16'hFF00;
  localparam logic [15:0] ADDR_STATUS = 16'hFF04;
  localparam logic [15:0] ADDR_RAMP   = 16'hFF08;

  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Configuration fields
  localparam int unsigned CFG_A_ORDER   = 7;
  localparam int unsigned CFG_B_ORDER   = 6;
  localparam int unsigned CFG_RATE_HI   = 5;
  localparam int unsigned CFG_RATE_LO   = 4;
  localparam int unsigned CFG_GLOBAL    = 3;
  localparam int unsigned CFG_P2_FORM   = 2;
  localparam int unsigned CFG_ODD_SEL   = 1;
  localparam int unsigned CFG_EVEN_SEL  = 0;
  // Control and status fields
  localparam int unsigned CTRL_ENABLE   = 0;
  localparam int unsigned CTRL_START    = 1;
  localparam int unsigned STAT_ACTIVE   = 0;
  localparam int unsigned STAT_DONE     = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ACSS_IDLE, ACSS_RAMP, ACSS_DONE} acss_state_t;

  // Switching cycles per 40 ns step for a rate code
  function automatic logic [3:0] acss_cycles_per_step(input logic [1:0] code);
    acss_cycles_per_step = 4'h1 << code;
  endfunction : acss_cycles_per_step
endpackage : acss_pkg

// file: tb/acss_chk.sv
// Checker of bus handshakes and soft start state at the top ports
`timescale 1ns/100ps
module acss_chk
  import acss_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [15:0] awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [15:0] araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        pwm_pin_1,
  input wire logic        pwm_pin_3,
  input wire logic        pwm_pin_5,
  input wire logic        pwm_pin_7,
  input wire logic        soft_start_active,
  input wire logic        soft_start_done
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic idle;
  logic wr_take;
  logic wr_bad;
  logic rd_bad;
  assign idle    = !soft_start_active && !soft_start_done;
  assign wr_take = awvalid && awready && wvalid && wready;
  assign wr_bad  = !(awaddr inside {ADDR_CFG, ADDR_CTRL, ADDR_STATUS, ADDR_RAMP});
  assign rd_bad  = !(araddr inside {ADDR_CFG, ADDR_CTRL, ADDR_STATUS, ADDR_RAMP});
  active_done_a: assert property (!(soft_start_active && soft_start_done))
    else $error("active and done together");
  // Odd pins only: outputs lag state by one cycle
  idle_pins_a: assert property (idle && $past(idle) |-> !pwm_pin_1 && !pwm_pin_3 && !pwm_pin_5 && !pwm_pin_7)
    else $error("pin high while idle");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read response dropped");
  wr_okay_a: assert property (wr_take && awaddr == ADDR_CFG |-> ##[1:3] bvalid && bresp == RESP_OKAY)
    else $error("config write not answered");
  wr_err_a: assert property (wr_take && wr_bad |-> ##[1:3] bvalid && bresp == RESP_SLVERR)
    else $error("bad write not refused");
  rd_next_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  rd_err_a: assert property (arvalid && arready && rd_bad |=> rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("bad read not refused");
  busy_refuse_a: assert property (bvalid |-> !awready && !wready)
    else $error("ready while response pending");
  cover property (soft_start_done);
  cover property (wr_take && wr_bad);
  cover property (rvalid && rresp == RESP_SLVERR);
endmodule : acss_chk
bind acss_top acss_chk i_acss_chk (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wvalid,
  .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
  .rready, .pwm_pin_1, .pwm_pin_3, .pwm_pin_5, .pwm_pin_7, .soft_start_active, .soft_start_done);

// file: tb/acss_stage.sv
// Power stage model that times the edges each switch sees
`timescale 1ns/100ps
module acss_stage (
  input  wire logic [7:0] pins,
  input  wire logic       aclk,
  output logic     [15:0] rgap [8],
  output logic     [15:0] fgap [8],
  output logic     [15:0] hlen [8]
);
  logic [15:0] now_reg = 16'h0000;
  logic [7:0]  pin_reg = 8'h00;
  logic [15:0] rise_at [8];
  logic [15:0] fall_at [8];
  // Gaps between like edges show which edge of a pulse stays put
  always_ff @(posedge aclk)
  begin
    now_reg <= now_reg + 16'h0001;
    pin_reg <= pins;
    for (int i = 0; i < 8; i++)
    begin
      if (pins[i] && !pin_reg[i])
      begin
        rgap[i]    <= now_reg - rise_at[i];
        rise_at[i] <= now_reg;
      end
      if (!pins[i] && pin_reg[i])
      begin
        fgap[i]    <= now_reg - fall_at[i];
        fall_at[i] <= now_reg;
        hlen[i]    <= now_reg - rise_at[i];
      end
    end
  end
endmodule : acss_stage

// file: tb/acss_top_bench.sv
// Self-checking bench for the aux channel soft start block
`timescale 1ns/100ps
module acss_top_bench
  import acss_pkg::*;
  ;
  typedef struct packed {logic [7:0] cfg; logic [31:0] ramp;} acss_row_t;
  acss_row_t rows [8] = '{'{8'h00, 32'h0018_0010}, '{8'h11, 32'h0028_0010},
    '{8'h22, 32'h0018_0020}, '{8'h34, 32'h0038_0010}, '{8'h88, 32'h0018_0018},
    '{8'hCC, 32'h0038_0038}, '{8'h4B, 32'h0018_0018}, '{8'h83, 32'h0028_0020}};
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [15:0] awaddr = 16'h0, araddr = 16'h0, period = 16'h0040;
  logic [31:0] wdata = 32'h0, d, rdata;
  logic [15:0] rise_t [8];
  logic [15:0] fall_t [8];
  logic [15:0] rgap [8];
  logic [15:0] fgap [8];
  logic [15:0] hlen [8];
  logic        awready, wready, bvalid, arready, rvalid, act, done;
  logic [1:0]  bresp, rresp, r;
  wire  [7:0]  pins;
  int          miscompares = 0, num_checks = 0, cyc = 0, t, n, mx;

  acss_top i_acss_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .period_ticks(period), .rise_ticks(rise_t), .fall_ticks(fall_t), .pwm_pin_1(pins[0]),
    .pwm_pin_2(pins[1]), .pwm_pin_3(pins[2]), .pwm_pin_4(pins[3]), .pwm_pin_5(pins[4]),
    .pwm_pin_6(pins[5]), .pwm_pin_7(pins[6]), .pwm_pin_8(pins[7]),
    .soft_start_active(act), .soft_start_done(done));
  acss_stage i_acss_stage (.pins(pins), .aclk(aclk), .rgap(rgap), .fgap(fgap), .hlen(hlen));

  always #2.5 aclk = ~aclk;

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // Ceiling sits well above the longest ramp sequence
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
  endtask : wr

  task automatic rd(input logic [15:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd

  // Disable first so every ramp starts from zero on-time
  task automatic run_ramp(input logic [7:0] c);
    wr(ADDR_CFG, {24'h0, c});
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, 32'h3);
  endtask : run_ramp

  initial
  begin
    for (int p = 0; p < 8; p++)
    begin
      rise_t[p] = 16'h0008;
      fall_t[p] = 16'(24 + 8 * (p % 4));
    end
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i])
    begin
      run_ramp(rows[i].cfg);
      t = 0;
      while (done !== 1'b1)
      begin
        @(posedge aclk);
        t++;
      end
      mx = (rows[i].ramp[31:16] > rows[i].ramp[15:0]) ? rows[i].ramp[31:16] : rows[i].ramp[15:0];
      n  = ((mx + 7) / 8) * (1 << rows[i].cfg[5:4]);
      check(32'(t >= (n - (1 << rows[i].cfg[5:4])) * 64 && t <= n * 64 + 72), 32'h1);
      rd(ADDR_RAMP);
      check(d, rows[i].ramp);
      rd(ADDR_STATUS);
      check(d, 32'h2);
      rd(ADDR_CFG);
      check(d, {24'h0, rows[i].cfg});
      repeat (130) @(posedge aclk);
      for (int p = 0; p < 8; p++) check(32'(hlen[p]), 32'(16 + 8 * (p % 4)));
    end
    wr(16'h0010, 32'hFF);
    check(32'(r), 32'(RESP_SLVERR));
    rd(16'h0010);
    check({d[29:0], r}, 32'(RESP_SLVERR));
    // Long period and rate 0: a wrongly anchored edge moves every cycle
    @(posedge aclk);
    period <= 16'h0100;
    for (int p = 0; p < 8; p++) fall_t[p] <= 16'h00C8;
    run_ramp(8'hC0);
    repeat (2560) @(posedge aclk);
    check(32'(rgap[0]), 32'h100);
    check(32'(rgap[2]), 32'h100);
    check(32'({act, done}), 32'h2);
    run_ramp(8'h80);
    repeat (2560) @(posedge aclk);
    check(32'(rgap[2]), 32'hFC);
    run_ramp(8'h40);
    repeat (2560) @(posedge aclk);
    check(32'(fgap[0]), 32'h100);
    check(32'(fgap[2]), 32'h100);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    check({act, done, pins}, 32'h0);
    repeat (2) @(posedge aclk);
    check({act, done, pins}, 32'h0);
    rd(ADDR_CFG);
    check(d, 32'(CFG_RESET));
    rd(ADDR_CTRL);
    check(d, 32'h0);
    report_and_stop();
  end
endmodule : acss_top_bench
